/* cmp_pkg.sv */
// Shared constants for the comparator control logic.
// Assumes a 32-bit Avalon-MM slave with one register per aligned word.
package cmp_pkg;
  localparam int            ADDR_W          = 4;
  localparam int            DATA_W          = 32;
  // Byte addresses, one word each
  localparam logic [3:0]    ADDR_CONTROL    = 4'h0;
  localparam logic [3:0]    ADDR_IRQ        = 4'h4;
  localparam logic [3:0]    ADDR_PINS       = 4'h8;
  // Control register fields
  localparam int            BIT_ON          = 6;
  localparam int            BIT_INVERT      = 5;
  localparam int            BIT_RESULT      = 4;
  localparam int            BIT_HYST        = 0;
  localparam logic [7:0]    CONTROL_RESET   = 8'h01;
  localparam logic [7:0]    CONTROL_WMASK   = 8'h61;
  // Interrupt register fields
  localparam int            BIT_IRQ_FLAG    = 0;
  localparam int            BIT_IRQ_EN      = 1;
  // Pin-function register fields
  localparam int            BIT_SEL_POS     = 0;
  localparam int            BIT_SEL_NEG     = 1;
  localparam int            BIT_SEL_OUT     = 2;
  localparam int            SYNC_STAGES     = 2;
endpackage

/* cmp_sync.sv */
// Two-flop synchroniser for the asynchronous comparator output.
// Assumes the analog output may change at any time.
`timescale 1ns/100ps
module cmp_sync (
  input  wire logic i_clk,
  input  wire logic i_nrst,
  input  wire logic i_ce,
  input  wire logic i_async,
  output logic      o_sync
);
  typedef struct packed {
    logic first;
    logic second;
  } sync_t;
  sync_t st_r;
  sync_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (i_ce) begin
      st_nxt.first  = i_async;
      st_nxt.second = st_r.first;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_sync = st_r.second;
endmodule

/* cmp_pin_read.sv */
// Read-back value of one comparator-shared port pin.
// Assumes port direction and data bits come from the port block.
`timescale 1ns/100ps
module cmp_pin_read (
  input  wire logic i_cmp_on,
  input  wire logic i_selected,
  input  wire logic i_dir_in,
  input  wire logic i_port_data,
  input  wire logic i_pin_level,
  output logic      o_read
);
  always_comb begin
    if (i_cmp_on && i_selected) begin
      // RQ14 shared pin read
      o_read = i_dir_in ? 1'b0 : i_port_data;
    end else begin
      o_read = i_dir_in ? i_pin_level : i_port_data;
    end
  end
endmodule

/* comparator_control_logic.sv */
// Control and status logic for the single analog comparator.
// Assumes an Avalon-MM master, an analog core with power, hysteresis and
// an asynchronous output, and a port block that reads pins back through here.
//
// How it works
// RQ1 - Comparator on bit zero powers the analog core down.
// RQ2 - Clearing comparator on forces the comparator output low.
// RQ3 - Output invert bit 5 passes the result straight or inverted.
// RQ4 - Result bit 4 reads one when inputs compare per invert setting.
// RQ5 - Bit 0 enables hysteresis, resets to one.
// RQ6 - Bits 7 and 3 to 1 read as zero.
// RQ7 - Any change of the result bit sets the interrupt flag.
// RQ8 - Flag and enable both set request the comparator vector.
// RQ9 - In sleep or idle a result toggle sets flag and wakes.
// RQ10 - Software presets the flag before sleep to suppress wake-up.
// RQ11 - Comparator stays active through sleep and idle when enabled.
// RQ12 - Selecting a comparator input pin disconnects its pull-high.
// RQ13 - Result readable in the register and routable to a pin.
// RQ14 - Enabled shared pin reads zero if direction is one, else data.
// RQ15 - Analog output is synchronised before polarity and change detection.
//
// The register addresses and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/100ps
module comparator_control_logic (
  input  wire logic                        i_clk,
  input  wire logic                        i_nrst,
  input  wire logic                        i_ce,
  input  wire logic [cmp_pkg::ADDR_W-1:0]  i_address,
  input  wire logic                        i_read,
  input  wire logic                        i_write,
  input  wire logic [cmp_pkg::DATA_W-1:0]  i_writedata,
  input  wire logic [3:0]                  i_byteenable,
  output logic      [cmp_pkg::DATA_W-1:0]  o_readdata,
  output logic                             o_waitrequest,
  output logic      [1:0]                  o_response,
  input  wire logic                        i_analog_out,
  input  wire logic                        i_sleep,
  input  wire logic [1:0]                  i_pin_dir_in,
  input  wire logic [1:0]                  i_pin_port_data,
  input  wire logic [1:0]                  i_pin_level,
  input  wire logic [1:0]                  i_pullup_request,
  output logic                             o_analog_power,
  output logic                             o_hysteresis_on,
  output logic                             o_result_pin,
  output logic                             o_result_pin_en,
  output logic      [1:0]                  o_pullup_en,
  output logic      [1:0]                  o_pin_read,
  output logic                             o_irq_request,
  output logic                             o_wake
);
  import cmp_pkg::*;

  typedef struct packed {
    logic        comparator_on;
    logic        output_invert;
    logic        hysteresis_on;
    logic        result_bit;
    logic        irq_flag;
    logic        irq_en;
    logic [2:0]  pin_sel;
    logic        busy;
    logic [31:0] readdata;
    logic [1:0]  response;
    logic        analog_power;
    logic        result_pin;
    logic        result_pin_en;
    logic [1:0]  pullup_en;
    logic [1:0]  pin_read;
    logic        irq_request;
    logic        wake;
  } state_t;

  state_t st_r;
  state_t st_nxt;
  logic   raw_sync;
  logic   [1:0] pin_read_w;

  // RQ15 clean edge source
  cmp_sync u_sync (
    .i_clk   (i_clk),
    .i_nrst  (i_nrst),
    .i_ce    (i_ce),
    .i_async (i_analog_out),
    .o_sync  (raw_sync)
  );

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_pin
      cmp_pin_read u_pin (
        .i_cmp_on    (st_r.comparator_on),
        .i_selected  (st_r.pin_sel[g]),
        .i_dir_in    (i_pin_dir_in[g]),
        .i_port_data (i_pin_port_data[g]),
        .i_pin_level (i_pin_level[g]),
        .o_read      (pin_read_w[g])
      );
    end
  endgenerate

  function automatic logic [7:0] control_image(input state_t s);
    logic [7:0] v;
    v = 8'h00;
    // RQ6 unimplemented bits zero
    v[BIT_ON]     = s.comparator_on;
    v[BIT_INVERT] = s.output_invert;
    v[BIT_RESULT] = s.result_bit;
    v[BIT_HYST]   = s.hysteresis_on;
    return v;
  endfunction

  logic       wr_ctl;
  logic       wr_irq;
  logic       new_result;
  logic       result_change;
  logic [7:0] ctl_next;

  always_comb begin
    st_nxt        = st_r;
    wr_ctl        = 1'b0;
    wr_irq        = 1'b0;
    ctl_next      = control_image(st_r);
    new_result    = 1'b0;
    result_change = 1'b0;
    if (i_ce) begin
      // One wait cycle per access, answer on the second edge
      if ((i_read || i_write) && !st_r.busy) begin
        st_nxt.busy = 1'b1;
      end else if (st_r.busy) begin
        st_nxt.busy = 1'b0;
      end
      if (st_r.busy && i_write && i_byteenable[0]) begin
        wr_ctl = (i_address == ADDR_CONTROL);
        wr_irq = (i_address == ADDR_IRQ);
        if (i_address == ADDR_PINS) begin
          st_nxt.pin_sel = i_writedata[2:0];
        end
      end
      if (wr_ctl) begin
        ctl_next = (i_writedata[7:0] & CONTROL_WMASK) | (ctl_next & ~CONTROL_WMASK);
        st_nxt.comparator_on = ctl_next[BIT_ON];
        st_nxt.output_invert = ctl_next[BIT_INVERT];
        st_nxt.hysteresis_on = ctl_next[BIT_HYST];
      end
      // RQ2 output forced low when off
      // RQ3 polarity applied to synced output
      // RQ4 result bit meaning
      new_result = st_nxt.comparator_on ? (raw_sync ^ st_nxt.output_invert) : 1'b0;
      result_change = (new_result != st_r.result_bit);
      st_nxt.result_bit = new_result;
      if (wr_irq) begin
        st_nxt.irq_flag = i_writedata[BIT_IRQ_FLAG];
        st_nxt.irq_en   = i_writedata[BIT_IRQ_EN];
      end
      // RQ7 change sets flag, set wins
      if (result_change) begin
        st_nxt.irq_flag = 1'b1;
      end
      if (st_r.busy && i_read) begin
        st_nxt.response = 2'h0;
        case (i_address)
          ADDR_CONTROL: st_nxt.readdata = {24'h000000, control_image(st_r)};
          ADDR_IRQ:     st_nxt.readdata = {30'h0, st_r.irq_en, st_r.irq_flag};
          ADDR_PINS:    st_nxt.readdata = {29'h0, st_r.pin_sel};
          default: begin
            st_nxt.readdata = 32'h00000000;
            st_nxt.response = 2'h2;
          end
        endcase
      end else if (st_r.busy && i_write) begin
        st_nxt.response = (i_address == ADDR_CONTROL || i_address == ADDR_IRQ ||
                           i_address == ADDR_PINS) ? 2'h0 : 2'h2;
      end
      // RQ1 RQ11 power follows on bit only
      st_nxt.analog_power  = st_nxt.comparator_on;
      st_nxt.result_pin    = st_nxt.result_bit;
      // RQ13 result routed to pin
      st_nxt.result_pin_en = st_nxt.pin_sel[BIT_SEL_OUT];
      // RQ12 pull-high off on input pins
      st_nxt.pullup_en[0]  = i_pullup_request[0] & ~st_nxt.pin_sel[BIT_SEL_POS];
      st_nxt.pullup_en[1]  = i_pullup_request[1] & ~st_nxt.pin_sel[BIT_SEL_NEG];
      st_nxt.pin_read      = pin_read_w;
      // RQ8 vector request
      st_nxt.irq_request   = st_nxt.irq_flag & st_nxt.irq_en;
      // RQ9 RQ10 wake on new flag only
      st_nxt.wake          = i_sleep & st_r.comparator_on & result_change & ~st_r.irq_flag;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r               <= '0;
      // RQ5 hysteresis resets on
      st_r.hysteresis_on <= CONTROL_RESET[BIT_HYST];
      st_r.busy          <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Wait is high until the answering edge
  // Also high while frozen, so no access completes unseen
  always_comb begin
    o_waitrequest = (i_read || i_write) ? (~st_r.busy | ~i_ce) : 1'b1;
  end

  assign o_readdata      = st_r.readdata;
  assign o_response      = st_r.response;
  assign o_analog_power  = st_r.analog_power;
  assign o_hysteresis_on = st_r.hysteresis_on;
  assign o_result_pin    = st_r.result_pin;
  assign o_result_pin_en = st_r.result_pin_en;
  assign o_pullup_en     = st_r.pullup_en;
  assign o_pin_read      = st_r.pin_read;
  assign o_irq_request   = st_r.irq_request;
  assign o_wake          = st_r.wake;
endmodule

/* cmp_ctrl_assertions.sv */
// Port checks for the comparator control block.
// Bound to comparator_control_logic; one clock domain.
`timescale 1ns/100ps
module cmp_ctrl_checker
  import cmp_pkg::*;
(
  input wire logic              i_clk,
  input wire logic              i_nrst,
  input wire logic [ADDR_W-1:0] i_address,
  input wire logic              i_read,
  input wire logic              i_write,
  input wire logic [DATA_W-1:0] i_writedata,
  input wire logic [3:0]        i_byteenable,
  input wire logic [DATA_W-1:0] o_readdata,
  input wire logic              o_waitrequest,
  input wire logic [1:0]        i_pullup_request,
  input wire logic              o_analog_power,
  input wire logic              o_hysteresis_on,
  input wire logic              o_result_pin,
  input wire logic [1:0]        o_pullup_en,
  input wire logic              o_wake
);
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);
  logic wr_c;
  logic rd_c;
  logic wr_p;
  // Writes without the low byte lane are ignored by the block
  assign wr_c = !o_waitrequest && i_write && i_byteenable[0] && i_address == ADDR_CONTROL;
  assign wr_p = !o_waitrequest && i_write && i_byteenable[0] && i_address == ADDR_PINS;
  assign rd_c = !o_waitrequest && i_read && i_address == ADDR_CONTROL;
  property p_on; wr_c |=> o_analog_power == $past(i_writedata[BIT_ON]); endproperty
  a_on: assert property (p_on) else $error("power bit");
  property p_hy; wr_c |=> o_hysteresis_on == $past(i_writedata[BIT_HYST]); endproperty
  a_hy: assert property (p_hy) else $error("hysteresis bit");
  property p_rb; rd_c |=> o_readdata[BIT_RESULT] == $past(o_result_pin); endproperty
  a_rb: assert property (p_rb) else $error("result readback");
  property p_rz; rd_c |=> o_readdata[7] == 1'h0 && o_readdata[3:1] == 3'h0; endproperty
  a_rz: assert property (p_rz) else $error("reserved bits");
  property p_off; !o_analog_power && !$past(o_analog_power) |-> !o_result_pin; endproperty
  a_off: assert property (p_off) else $error("result while off");
  property p_pu; (o_pullup_en & ~$past(i_pullup_request)) == 2'h0; endproperty
  a_pu: assert property (p_pu) else $error("pull-high");
  property p_pd; wr_p |=> (o_pullup_en & $past(i_writedata[1:0])) == 2'h0; endproperty
  a_pd: assert property (p_pd) else $error("pull-high on selected input pin");
  property p_wk; o_wake |=> !o_wake; endproperty
  a_wk: assert property (p_wk) else $error("wake width");
  property p_st; !$past(wr_c) |-> $stable(o_analog_power); endproperty
  a_st: assert property (p_st) else $error("power changed");
endmodule
bind comparator_control_logic cmp_ctrl_checker u_chk (.*);

/* cmp_analog_model.sv */
// Behavioural analog comparator core.
// Bench says which input is higher; output is asynchronous.
`timescale 1ns/100ps
module cmp_analog_model (
  input  wire logic i_clk,
  input  wire logic i_power,
  input  wire logic i_pos_higher,
  output logic      o_out
);
  logic noise_r = 1'h0;
  // Unpowered output means nothing, so it wanders
  always @(posedge i_clk) noise_r <= ~noise_r;
  assign o_out = i_power ? i_pos_higher : noise_r;
endmodule

/* testbench.sv */
// Self-checking bench for comparator_control_logic.
// Assumes the bound checker and the analog core model.
`timescale 1ns/100ps
`define CHK(n, e, g) begin samples_checked++; \
  if ((g) !== (e)) begin fail_count++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module testbench;
  import cmp_pkg::*;
  logic        i_clk = 1'h0, i_nrst = 1'h0, i_ce = 1'h1, i_read = 1'h0, i_write = 1'h0;
  logic        i_sleep = 1'h0, pos_hi = 1'h0;
  logic [3:0]  i_address = 4'h0, i_byteenable = 4'hf;
  logic [31:0] i_writedata = 32'h0, o_readdata, r;
  logic [1:0]  i_pin_dir_in = 2'h0, i_pin_port_data = 2'h0, i_pin_level = 2'h0, i_pullup_request = 2'h0;
  logic [1:0]  o_response, o_pullup_en, o_pin_read;
  logic        o_waitrequest, i_analog_out, o_analog_power, o_hysteresis_on, o_result_pin;
  logic        o_result_pin_en, o_irq_request, o_wake;
  logic [33:0] exp_q[$], e_v;
  logic [7:0]  d;
  int          fail_count = 0, samples_checked = 0, wakes = 0, cycles = 0, seed = 16;
  cmp_analog_model core (.i_clk, .i_power(o_analog_power), .i_pos_higher(pos_hi), .o_out(i_analog_out));
  comparator_control_logic uut (.*);
  always #5 i_clk = ~i_clk;
  task automatic bus(input logic [3:0] a, input logic w, input logic [7:0] v);
    @(posedge i_clk);
    i_address <= a;
    i_writedata <= {24'h0, v};
    i_read <= !w;
    i_write <= w;
    do @(posedge i_clk); while (o_waitrequest !== 1'h0);
    i_read <= 1'h0;
    i_write <= 1'h0;
    @(negedge i_clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [1:0] s);
    exp_q.push_back({s, 24'h0, e});
    bus(a, 1'h0, 8'h0);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge i_clk) begin
    if (o_wake === 1'h1) wakes++;
    if (i_read === 1'h1 && o_waitrequest === 1'h0 && exp_q.size() > 0) begin
      e_v = exp_q.pop_front();
      #1 `CHK("readback", e_v, {o_response, o_readdata})
    end
    if (++cycles == 3000) begin
      fail_count++;
      print_verdict();
    end
  end
  initial begin
    repeat (20) @(posedge i_clk);
    i_nrst <= 1'h1;
    rd(ADDR_CONTROL, CONTROL_RESET, 2'h0);
    `CHK("hyst", 1'h1, o_hysteresis_on)
    $display("test reset done");
    for (int k = 0; k < 4; k++) begin
      d = 8'($random(seed)) | 8'h41;
      d[BIT_INVERT] = k[1];
      pos_hi <= k[0];
      bus(ADDR_CONTROL, 1'h1, d);
      repeat (5) @(posedge i_clk);
      rd(ADDR_CONTROL, (d & CONTROL_WMASK) | {3'h0, k[0] ^ k[1], 4'h0}, 2'h0);
      `CHK("result pin", k[0] ^ k[1], o_result_pin)
    end
    $display("test polarity done");
    @(posedge i_clk);
    i_sleep <= 1'h1;
    bus(ADDR_IRQ, 1'h1, 8'h02);
    wakes = 0;
    pos_hi <= 1'h0;
    repeat (6) @(posedge i_clk);
    rd(ADDR_IRQ, 8'h03, 2'h0);
    `CHK("irq", 1'h1, o_irq_request)
    `CHK("wake", 1, wakes)
    bus(ADDR_IRQ, 1'h1, 8'h01);
    pos_hi <= 1'h1;
    repeat (6) @(negedge i_clk);
    `CHK("no wake", 1, wakes)
    `CHK("irq masked", 1'h0, o_irq_request)
    @(posedge i_clk);
    i_sleep <= 1'h0;
    $display("test interrupt done");
    pos_hi <= 1'h0;
    bus(ADDR_IRQ, 1'h1, 8'h00);
    bus(ADDR_CONTROL, 1'h1, 8'h20);
    // Low lane disabled: this write must be ignored
    @(posedge i_clk);
    i_byteenable <= 4'he;
    bus(ADDR_CONTROL, 1'h1, 8'h41);
    @(posedge i_clk);
    i_byteenable <= 4'hf;
    repeat (6) @(posedge i_clk);
    rd(ADDR_CONTROL, 8'h20, 2'h0);
    rd(ADDR_IRQ, 8'h01, 2'h0);
    `CHK("power", 1'h0, o_analog_power)
    rd(4'hc, 8'h00, 2'h2);
    $display("test off done");
    bus(ADDR_CONTROL, 1'h1, 8'h41);
    for (int k = 0; k < 8; k++) begin
      r = $random(seed);
      @(posedge i_clk);
      {i_pin_dir_in, i_pin_port_data, i_pin_level, i_pullup_request} <= r[7:0];
      bus(ADDR_PINS, 1'h1, {5'h0, r[10:8]});
      @(negedge i_clk);
      `CHK("pullup", r[1:0] & ~r[9:8], o_pullup_en)
      `CHK("pin read", (~r[7:6] & r[5:4]) | (~r[9:8] & r[7:6] & r[3:2]), o_pin_read)
      `CHK("out route", r[10], o_result_pin_en)
    end
    $display("test pins done");
    print_verdict();
  end
endmodule
